// File: verif/async_wait_partner.sv
// behavioural asynchronous memory that holds the wait pin for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module async_wait_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic access,
	input wire logic [7:0] hold,
	output logic ext_wait
);
	logic access_q;
	logic [7:0] cnt_q;
	// a slow device stretches its access; hold of zero answers at once
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			access_q <= 1'b0;
			cnt_q <= 8'h00;
		end
		else
		begin
			access_q <= access;
			if (access && !access_q)
				cnt_q <= hold;
			else if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
		end
	end
	// the pin idles inactive, as a board pull-down would leave it
	assign ext_wait = (cnt_q != 8'h00);
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the sdram timing guard and interrupt status registers
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_n, rd, wr, cv, sre, acc, ew, lt, wreq, crdy, ival, irq, xw;
	logic [7:0] adr, hold;
	logic [31:0] wd, rdd, rdata, cyc, last;
	logic [3:0] be;
	sdram_regs_pkg::cmd_s cin, ccmd, icmd;
	sdram_regs_pkg::sdram_timing_s tm;
	int error_cnt, tests_run, irqs;
	bit pend;

	sdram_timing_irq_regs sdram_timing_irq_regs_inst (.CORE_CLK(clk), .RESET_N(rst_n),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdd), .AVS_WAITREQUEST(wreq), .CMD_VALID(cv),
		.CMD_IN(cin), .CMD_READY(crdy), .ISSUED_VALID(ival), .ISSUED_CMD(icmd),
		.SELF_REFRESH_EXIT(sre), .EXT_WAIT(xw), .ASYNC_EXT_ACCESS(acc),
		.EXTENDED_WAIT_ENABLE(ew), .LINE_TRAP_EVENT(lt), .IRQ_TIMEOUT(irq));
	async_wait_partner async_wait_partner_inst (.clk(clk), .rst_n(rst_n), .access(acc),
		.hold(hold), .ext_wait(xw));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (irq)
			irqs <= irqs + 1;
	end

	task final_report;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// request held from one edge until the edge that sees waitrequest low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (wreq !== 1'b0)
		begin
			error_cnt++;
			$display("BAD %0t bus request never answered", $time);
		end
		rdata = rdd;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask

	// called on an edge; valid stays up so a zero-field gap can be seen as one cycle
	task issue(input sdram_regs_pkg::cmd_kind_e k, input logic [1:0] b, input int gap);
		int n;
		n = 0;
		cv <= 1'b1;
		cin <= '{k, b};
		#1;
		if (pend)
			chk(32'({ival, icmd}), 32'({1'b1, ccmd}));
		while (crdy !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (crdy !== 1'b1)
		begin
			error_cnt++;
			$display("BAD %0t command never became ready", $time);
		end
		@(posedge clk);
		if (gap > 0)
			chk(cyc - last, 32'(gap));
		last = cyc;
		ccmd = '{k, b};
		pend = 1'b1;
	endtask

	task idle;
		cv <= 1'b0;
		#1;
		if (pend)
			chk(32'({ival, icmd}), 32'({1'b1, ccmd}));
		pend = 1'b0;
		@(posedge clk);
	endtask

	task wacc(input logic e, input logic [7:0] h);
		ew <= e;
		hold <= h;
		acc <= 1'b1;
		repeat (32) @(posedge clk);
		acc <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task trap;
		lt <= 1'b1;
		@(posedge clk);
		lt <= 1'b0;
		@(posedge clk);
	endtask

	initial
	begin
		#400000;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		final_report;
	end

	initial
	begin
		{rst_n, rd, wr, cv, sre, acc, ew, lt, pend} = '0;
		{adr, hold, wd, cyc, last} = '0;
		be = 4'hf;
		cin = '0;
		{irqs, error_cnt, tests_run} = '0;
		tm = sdram_regs_pkg::TIMING_RESET;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk(sdram_regs_pkg::OFS_TIMING, sdram_regs_pkg::TIMING_RESET);
		rchk(sdram_regs_pkg::OFS_SR_EXIT, 32'h1f);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h0);
		rchk(sdram_regs_pkg::OFS_MASKED, 32'h0);
		rchk(sdram_regs_pkg::OFS_EN_SET, 32'h0);
		rchk(sdram_regs_pkg::OFS_WAIT_CFG, 32'h80);
		bus(1'b1, 8'h40, 32'hffffffff);
		rchk(8'h40, 32'h0);
		bus(1'b1, sdram_regs_pkg::OFS_TIMING, 32'hffffffff);
		rchk(sdram_regs_pkg::OFS_TIMING, 32'hff77ff70);
		bus(1'b1, sdram_regs_pkg::OFS_SR_EXIT, 32'hffffffff);
		rchk(sdram_regs_pkg::OFS_SR_EXIT, 32'h1f);
		bus(1'b1, sdram_regs_pkg::OFS_TIMING, tm);
		issue(sdram_regs_pkg::CMD_ACT, 2'h0, 0);
		issue(sdram_regs_pkg::CMD_RD, 2'h0, tm.row_to_column_delay + 1);
		issue(sdram_regs_pkg::CMD_PRE, 2'h0, tm.row_active - tm.row_to_column_delay);
		issue(sdram_regs_pkg::CMD_REF, 2'h0, tm.precharge_period + 1);
		issue(sdram_regs_pkg::CMD_REF, 2'h0, tm.refresh_interval + 1);
		issue(sdram_regs_pkg::CMD_ACT, 2'h0, 0);
		issue(sdram_regs_pkg::CMD_ACT, 2'h0, tm.row_cycle_time + 1);
		idle;
		tm = 32'h42040030;
		bus(1'b1, sdram_regs_pkg::OFS_TIMING, tm);
		repeat (10) @(posedge clk);
		issue(sdram_regs_pkg::CMD_ACT, 2'h0, 0);
		issue(sdram_regs_pkg::CMD_ACT, 2'h1, tm.bank_to_bank_activate + 1);
		issue(sdram_regs_pkg::CMD_WR, 2'h1, tm.row_to_column_delay + 1);
		issue(sdram_regs_pkg::CMD_PRE, 2'h1, tm.write_recovery + 1);
		idle;
		bus(1'b1, sdram_regs_pkg::OFS_SR_EXIT, 32'h3);
		repeat (4) @(posedge clk);
		sre <= 1'b1;
		@(posedge clk);
		sre <= 1'b0;
		last = cyc;
		issue(sdram_regs_pkg::CMD_ACT, 2'h0, 3 + 1);
		idle;
		bus(1'b1, sdram_regs_pkg::OFS_WAIT_CFG, 32'h4);
		bus(1'b1, sdram_regs_pkg::OFS_EN_SET, 32'h1);
		rchk(sdram_regs_pkg::OFS_EN_CLR, 32'h1);
		wacc(1'b1, 8'd20);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h5);
		rchk(sdram_regs_pkg::OFS_MASKED, 32'h1);
		chk(32'(irqs), 32'h1);
		bus(1'b1, sdram_regs_pkg::OFS_RAW, 32'h0);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h5);
		bus(1'b1, sdram_regs_pkg::OFS_RAW, 32'h1);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h4);
		rchk(sdram_regs_pkg::OFS_MASKED, 32'h0);
		bus(1'b1, sdram_regs_pkg::OFS_MASKED, 32'h4);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h0);
		wacc(1'b1, 8'd2);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h4);
		bus(1'b1, sdram_regs_pkg::OFS_RAW, 32'h7);
		wacc(1'b0, 8'd20);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h4);
		bus(1'b1, sdram_regs_pkg::OFS_RAW, 32'h7);
		chk(32'(irqs), 32'h1);
		bus(1'b1, sdram_regs_pkg::OFS_EN_SET, 32'h2);
		trap;
		rchk(sdram_regs_pkg::OFS_MASKED, 32'h2);
		bus(1'b1, sdram_regs_pkg::OFS_EN_CLR, 32'h3);
		rchk(sdram_regs_pkg::OFS_EN_SET, 32'h0);
		bus(1'b1, sdram_regs_pkg::OFS_MASKED, 32'h2);
		rchk(sdram_regs_pkg::OFS_RAW, 32'h0);
		trap;
		rchk(sdram_regs_pkg::OFS_RAW, 32'h2);
		rchk(sdram_regs_pkg::OFS_MASKED, 32'h0);
		final_report;
	end
endmodule
`default_nettype wire

// File: verilog/sdram_regs_pkg.sv
// shared constants and types for the sdram timing and interrupt status registers
`default_nettype none
package sdram_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BANK_W = 2;
	localparam int IRQ_W = 3;
	localparam int WAIT_CNT_W = 8;
	localparam int SINCE_W = 6;
	localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SR_EXIT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RAW = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MASKED = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_EN_SET = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EN_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_WAIT_CFG = 8'h18;
	localparam logic [DATA_W-1:0] TIMING_RESET = 32'h42215810;
	localparam logic [DATA_W-1:0] TIMING_WMASK = 32'hff77ff70;
	localparam logic [DATA_W-1:0] SR_EXIT_RESET = 32'h0000001f;
	localparam logic [DATA_W-1:0] SR_EXIT_WMASK = 32'h0000001f;
	localparam logic [DATA_W-1:0] WAIT_CFG_RESET = 32'h00000080;
	localparam logic [DATA_W-1:0] WAIT_CFG_WMASK = 32'h000000ff;
	localparam int BIT_TIMEOUT = 0;
	localparam int BIT_LINE_TRAP = 1;
	localparam int BIT_WAIT_RISE = 2;
	localparam int RFC_W = 5;
	localparam int RP_W = 3;
	localparam int RCD_W = 3;
	localparam int WR_W = 3;
	localparam int RAS_W = 4;
	localparam int RC_W = 4;
	localparam int RRD_W = 3;
	localparam int XS_W = 5;
	typedef struct packed {
		logic [RFC_W-1:0] refresh_interval;
		logic [RP_W-1:0] precharge_period;
		logic rsvd23;
		logic [RCD_W-1:0] row_to_column_delay;
		logic rsvd19;
		logic [WR_W-1:0] write_recovery;
		logic [RAS_W-1:0] row_active;
		logic [RC_W-1:0] row_cycle_time;
		logic rsvd7;
		logic [RRD_W-1:0] bank_to_bank_activate;
		logic [3:0] rsvd3_0;
	} sdram_timing_s;
	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF} cmd_kind_e;
	typedef struct packed {
		cmd_kind_e kind;
		logic [BANK_W-1:0] bank;
	} cmd_s;
	typedef enum {TO_IDLE, TO_COUNT, TO_DONE} timeout_state_e;
endpackage
`default_nettype wire

// File: verilog/sdram_timing_irq_regs.sv
// sdram command spacing guard with timing, self-refresh exit and interrupt status registers
// Function
// - refresh to refresh at least field plus one
// - precharge to activate or refresh spacing
// - activate to read or write spacing
// - write to precharge recovery spacing
// - activate to precharge row active time
// - activate to activate row cycle spacing
// - activates to other banks spaced apart
// - reserved bits always read back zero
// - self-refresh exit delay before any command
// - wait held too long sets timeout flag
// - raw flags set regardless of enables
// - wait input rising edge sets flag
// - bad access type sets line trap
// - raw write one clears raw and masked
// - masked flag set only when enabled
// - masked timeout set pulses interrupt output
// - masked write one clears both bits
// - no wait pin makes status reserved
// - enable set and clear registers
// - timeout only with extended wait enabled
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module spacing_timer #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] cnt_q;

	// limit is captured at the start so a later register write cannot shorten a running gap
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (start)
			cnt_q <= limit;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign done = (cnt_q == '0);
endmodule

module sdram_timing_irq_regs #(
	parameter bit HAS_WAIT_PIN = 1'b1
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [sdram_regs_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [sdram_regs_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [sdram_regs_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic CMD_VALID,
	input wire sdram_regs_pkg::cmd_s CMD_IN,
	output logic CMD_READY,
	output logic ISSUED_VALID,
	output sdram_regs_pkg::cmd_s ISSUED_CMD,
	input wire logic SELF_REFRESH_EXIT,
	input wire logic EXT_WAIT,
	input wire logic ASYNC_EXT_ACCESS,
	input wire logic EXTENDED_WAIT_ENABLE,
	input wire logic LINE_TRAP_EVENT,
	output logic IRQ_TIMEOUT
);
	localparam logic [sdram_regs_pkg::IRQ_W-1:0] STAT_MASK = HAS_WAIT_PIN ? 3'h7 : 3'h0;

	logic ack_q, wr_en, irq_q, wait_s_q, wait_rise, timeout_evt;
	logic [31:0] rdata_q, rd_mux, be_mask, timing_q, sr_exit_q, wait_cfg_q;
	logic [2:0] raw_q, raw_d, masked_q, masked_d, en_q, evt, clr, wait_sync_q;
	sdram_regs_pkg::sdram_timing_s tim;
	sdram_regs_pkg::timeout_state_e to_state_q;
	logic [sdram_regs_pkg::WAIT_CNT_W-1:0] wait_cnt_q;
	logic ref_ok, pre_ok, rcd_ok, wr_ok, ras_ok, rc_ok, rrd_ok, xs_ok;
	logic go, act_go, rw_go, wr_go, pre_go, ref_go, issued_valid_q;
	logic [sdram_regs_pkg::BANK_W-1:0] last_bank_q;
	sdram_regs_pkg::cmd_s issued_cmd_q;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	assign tim = sdram_regs_pkg::sdram_timing_s'(timing_q);

	// one wait state: request seen, then answered with registered read data
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign wr_en = AVS_WRITE & ack_q;
	assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			ack_q <= 1'b0;
		else
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (AVS_ADDRESS)
			sdram_regs_pkg::OFS_TIMING: rd_mux = timing_q & sdram_regs_pkg::TIMING_WMASK;
			sdram_regs_pkg::OFS_SR_EXIT: rd_mux = sr_exit_q & sdram_regs_pkg::SR_EXIT_WMASK;
			sdram_regs_pkg::OFS_RAW: rd_mux = {29'h0, raw_q & STAT_MASK};
			sdram_regs_pkg::OFS_MASKED: rd_mux = {29'h0, masked_q & STAT_MASK};
			sdram_regs_pkg::OFS_EN_SET: rd_mux = {29'h0, en_q & STAT_MASK};
			sdram_regs_pkg::OFS_EN_CLR: rd_mux = {29'h0, en_q & STAT_MASK};
			sdram_regs_pkg::OFS_WAIT_CFG: rd_mux = wait_cfg_q & sdram_regs_pkg::WAIT_CFG_WMASK;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			rdata_q <= 32'h00000000;
		else if (AVS_READ & ~ack_q)
			rdata_q <= rd_mux;
	end

	assign AVS_READDATA = rdata_q;

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			timing_q <= sdram_regs_pkg::TIMING_RESET;
		else if (wr_en && AVS_ADDRESS == sdram_regs_pkg::OFS_TIMING)
			timing_q <= (timing_q & ~be_mask) | (AVS_WRITEDATA & be_mask & sdram_regs_pkg::TIMING_WMASK);
	end
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			sr_exit_q <= sdram_regs_pkg::SR_EXIT_RESET;
		else if (wr_en && AVS_ADDRESS == sdram_regs_pkg::OFS_SR_EXIT)
			sr_exit_q <= (sr_exit_q & ~be_mask) | (AVS_WRITEDATA & be_mask & sdram_regs_pkg::SR_EXIT_WMASK);
	end
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			wait_cfg_q <= sdram_regs_pkg::WAIT_CFG_RESET;
		else if (wr_en && AVS_ADDRESS == sdram_regs_pkg::OFS_WAIT_CFG)
			wait_cfg_q <= (wait_cfg_q & ~be_mask) | (AVS_WRITEDATA & be_mask & sdram_regs_pkg::WAIT_CFG_WMASK);
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			en_q <= 3'h0;
		else if (wr_en && AVS_BYTEENABLE[0] && AVS_ADDRESS == sdram_regs_pkg::OFS_EN_SET)
			en_q <= en_q | (AVS_WRITEDATA[2:0] & STAT_MASK);
		else if (wr_en && AVS_BYTEENABLE[0] && AVS_ADDRESS == sdram_regs_pkg::OFS_EN_CLR)
			en_q <= en_q & ~AVS_WRITEDATA[2:0];
	end

	// pin filter: third stage must agree with the second before a change is believed
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			wait_sync_q <= 3'h0;
			wait_s_q <= 1'b0;
		end
		else
		begin
			wait_sync_q <= {wait_sync_q[1:0], EXT_WAIT};
			if (wait_sync_q[1] == wait_sync_q[2])
				wait_s_q <= wait_sync_q[1];
		end
	end

	assign wait_rise = wait_sync_q[1] & wait_sync_q[2] & ~wait_s_q;

	// one timeout per access; the count restarts whenever wait drops
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			to_state_q <= sdram_regs_pkg::TO_IDLE;
			wait_cnt_q <= '0;
		end
		else
		begin
			unique case (to_state_q)
				sdram_regs_pkg::TO_IDLE:
				begin
					wait_cnt_q <= '0;
					if (ASYNC_EXT_ACCESS && EXTENDED_WAIT_ENABLE)
						to_state_q <= sdram_regs_pkg::TO_COUNT;
				end
				sdram_regs_pkg::TO_COUNT:
				begin
					if (!ASYNC_EXT_ACCESS)
						to_state_q <= sdram_regs_pkg::TO_IDLE;
					else if (timeout_evt)
						to_state_q <= sdram_regs_pkg::TO_DONE;
					else if (wait_s_q)
						wait_cnt_q <= wait_cnt_q + 1'b1;
					else
						wait_cnt_q <= '0;
				end
				sdram_regs_pkg::TO_DONE:
				begin
					if (!ASYNC_EXT_ACCESS)
						to_state_q <= sdram_regs_pkg::TO_IDLE;
				end
			endcase
		end
	end

	assign timeout_evt = (to_state_q == sdram_regs_pkg::TO_COUNT) && ASYNC_EXT_ACCESS && wait_s_q
		&& (wait_cnt_q == wait_cfg_q[sdram_regs_pkg::WAIT_CNT_W-1:0]);

	assign evt[sdram_regs_pkg::BIT_TIMEOUT] = timeout_evt;
	assign evt[sdram_regs_pkg::BIT_LINE_TRAP] = LINE_TRAP_EVENT;
	assign evt[sdram_regs_pkg::BIT_WAIT_RISE] = wait_rise;

	// a set in the same cycle as a clear wins, so no event is lost
	always_comb
	begin
		clr = 3'h0;
		if (wr_en && AVS_BYTEENABLE[0] && (AVS_ADDRESS == sdram_regs_pkg::OFS_RAW
			|| AVS_ADDRESS == sdram_regs_pkg::OFS_MASKED))
			clr = AVS_WRITEDATA[2:0];
		raw_d = ((evt & STAT_MASK) | (raw_q & ~clr));
		masked_d = ((evt & en_q & STAT_MASK) | (masked_q & ~clr));
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			raw_q <= 3'h0;
			masked_q <= 3'h0;
		end
		else
		begin
			raw_q <= raw_d;
			masked_q <= masked_d;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			irq_q <= 1'b0;
		else
			irq_q <= masked_d[sdram_regs_pkg::BIT_TIMEOUT] & ~masked_q[sdram_regs_pkg::BIT_TIMEOUT];
	end

	assign IRQ_TIMEOUT = irq_q;

	spacing_timer #(.W(sdram_regs_pkg::RFC_W)) u_rfc (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(ref_go), .limit(tim.refresh_interval), .done(ref_ok));
	spacing_timer #(.W(sdram_regs_pkg::RP_W)) u_rp (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(pre_go), .limit(tim.precharge_period), .done(pre_ok));
	spacing_timer #(.W(sdram_regs_pkg::RCD_W)) u_rcd (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(act_go), .limit(tim.row_to_column_delay), .done(rcd_ok));
	spacing_timer #(.W(sdram_regs_pkg::WR_W)) u_wr (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(wr_go), .limit(tim.write_recovery), .done(wr_ok));
	spacing_timer #(.W(sdram_regs_pkg::RAS_W)) u_ras (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(act_go), .limit(tim.row_active), .done(ras_ok));
	spacing_timer #(.W(sdram_regs_pkg::RC_W)) u_rc (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(act_go), .limit(tim.row_cycle_time), .done(rc_ok));
	spacing_timer #(.W(sdram_regs_pkg::RRD_W)) u_rrd (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(act_go), .limit(tim.bank_to_bank_activate), .done(rrd_ok));
	spacing_timer #(.W(sdram_regs_pkg::XS_W)) u_xs (.clk(CORE_CLK), .rst_n(RESET_N),
		.start(SELF_REFRESH_EXIT), .limit(sr_exit_q[sdram_regs_pkg::XS_W-1:0]), .done(xs_ok));

	// gaps are tracked across all banks, which is conservative for same-bank row cycle
	always_comb
	begin
		CMD_READY = 1'b0;
		unique case (CMD_IN.kind)
			sdram_regs_pkg::CMD_NOP: CMD_READY = 1'b1;
			sdram_regs_pkg::CMD_ACT: CMD_READY = pre_ok && rc_ok && (rrd_ok || CMD_IN.bank == last_bank_q);
			sdram_regs_pkg::CMD_RD: CMD_READY = rcd_ok;
			sdram_regs_pkg::CMD_WR: CMD_READY = rcd_ok;
			sdram_regs_pkg::CMD_PRE: CMD_READY = wr_ok && ras_ok;
			sdram_regs_pkg::CMD_REF: CMD_READY = ref_ok && pre_ok;
			default: CMD_READY = 1'b0;
		endcase
		if (!xs_ok || SELF_REFRESH_EXIT)
			CMD_READY = 1'b0;
	end

	assign go = CMD_VALID && CMD_READY && CMD_IN.kind != sdram_regs_pkg::CMD_NOP;
	assign act_go = go && CMD_IN.kind == sdram_regs_pkg::CMD_ACT;
	assign wr_go = go && CMD_IN.kind == sdram_regs_pkg::CMD_WR;
	assign rw_go = wr_go || (go && CMD_IN.kind == sdram_regs_pkg::CMD_RD);
	assign pre_go = go && CMD_IN.kind == sdram_regs_pkg::CMD_PRE;
	assign ref_go = go && CMD_IN.kind == sdram_regs_pkg::CMD_REF;

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			last_bank_q <= '0;
		else if (act_go)
			last_bank_q <= CMD_IN.bank;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			issued_valid_q <= 1'b0;
			issued_cmd_q <= '0;
		end
		else
		begin
			issued_valid_q <= go;
			if (go)
				issued_cmd_q <= CMD_IN;
		end
	end

	assign ISSUED_VALID = issued_valid_q;
	assign ISSUED_CMD = issued_cmd_q;

	// cycles since each activate, precharge, refresh, write and self-refresh exit, counted from one so a gap of n edges reads n
	logic [4:0] since_ev;
	logic [sdram_regs_pkg::SINCE_W-1:0] since_q [5];
	assign since_ev = {SELF_REFRESH_EXIT, wr_go, ref_go, pre_go, act_go};

	for (genvar i = 0; i < 5; i++)
	begin : g_since
		always_ff @(posedge CORE_CLK)
		begin
			if (!RESET_N)
				since_q[i] <= '1;
			else if (since_ev[i])
				since_q[i] <= sdram_regs_pkg::SINCE_W'(1);
			else if (since_q[i] != '1)
				since_q[i] <= since_q[i] + 1'b1;
		end
	end

	property p_ref_gap;
		ref_go |-> since_q[2] > 6'(tim.refresh_interval);
	endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("refresh too soon");
	property p_pre_gap;
		(act_go || ref_go) |-> since_q[1] > 6'(tim.precharge_period);
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("precharge gap short");
	property p_rcd_gap;
		rw_go |-> since_q[0] > 6'(tim.row_to_column_delay);
	endproperty
	a_rcd_gap: assert property (p_rcd_gap) else $error("column command too soon");
	property p_wr_gap;
		pre_go |-> since_q[3] > 6'(tim.write_recovery) && since_q[0] > 6'(tim.row_active);
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("precharge too soon");
	property p_act_gap;
		act_go |-> since_q[0] > 6'(tim.row_cycle_time)
			&& (CMD_IN.bank == last_bank_q || since_q[0] > 6'(tim.bank_to_bank_activate));
	endproperty
	a_act_gap: assert property (p_act_gap) else $error("activate too soon");
	property p_xs_gap;
		go |-> since_q[4] > 6'(sr_exit_q[4:0]);
	endproperty
	a_xs_gap: assert property (p_xs_gap) else $error("command during self refresh exit");
	property p_timeout_set;
		timeout_evt |=> raw_q[0] ##1 (raw_q[0] || $past(clr[0]));
	endproperty
	a_timeout_set: assert property (p_timeout_set) else $error("timeout flag lost");
	property p_masked_gate;
		$rose(masked_q[0]) |-> $past(en_q[0]) && raw_q[0];
	endproperty
	a_masked_gate: assert property (p_masked_gate) else $error("masked set while disabled");
	property p_irq_pulse;
		$rose(masked_q[0]) |-> IRQ_TIMEOUT ##1 !IRQ_TIMEOUT;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("no single interrupt pulse");
	property p_w1c;
		(wr_en && AVS_ADDRESS == sdram_regs_pkg::OFS_RAW && AVS_BYTEENABLE[0]
			&& AVS_WRITEDATA[1] && !LINE_TRAP_EVENT) |=> !raw_q[1] && !masked_q[1];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");
	property p_rise;
		wait_rise |=> raw_q[2] == HAS_WAIT_PIN;
	endproperty
	a_rise: assert property (p_rise) else $error("wait rise not flagged");
	property p_rsvd;
		(ack_q && AVS_READ && AVS_ADDRESS == sdram_regs_pkg::OFS_TIMING)
			|-> AVS_READDATA[23] == 1'b0 && AVS_READDATA[19] == 1'b0 && AVS_READDATA[3:0] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule
`default_nettype wire
